// *** logic/ppivr_regs.sv ***
// paged vendor identification and vendor control registers of a cable phy
//
// Operation
// - page select value 1 in base register 7 maps identification page
// - page select value 7 in base register 7 maps vendor control page
// - identification page address 1000b reads fixed compliance level 01h
// - 24-bit maker oui read-only, msb at address 1010b
// - 24-bit part identifier read-only, msb at address 1101b
// - null-packet action flag is read-write, steers request clearing
// - flag set: only packets longer than 8 bits clear requests
// - flag clear: any non-ack packet clears requests, null or malformed too
// - system reset clears the null-packet action flag
// - 2-bit read-write link speed field
// - power class straps give default of self-id power field
// - straps loaded after reset; later register 4 write replaces them
// - power code 000: no power needed, none repeated
// - codes 001 to 011: self-powered, 15, 30, 45 W supplied
// - code 100: may be bus powered, 3 W, link needs nothing; 101 reserved
// - codes 110, 111: bus powered 3 W, link needs 3 or 7 W more
`timescale 1ns/100ps
`include "ppivr_defs.svh"
module ppivr_regs #(
   parameter logic [23:0] MAKER_OUI = `PPIVR_OUI_DEFAULT, // value arbitrary
   parameter logic [23:0] PART_IDENT = `PPIVR_PART_DEFAULT // value arbitrary
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [2:0] power_class_straps_in,
   input wire logic pkt_end_in,
   input wire logic [15:0] pkt_bits_in,
   input wire logic req_set_in,
   output logic [7:0] reg_rdata_out,
   output logic [2:0] page_sel_out,
   output logic null_packet_action_flag_out,
   output logic [1:0] link_speed_out,
   output logic [2:0] self_id_pwr_out,
   output logic arb_req_pending_out
);
   logic [2:0] page_reg;
   logic null_flag_reg;
   logic [1:0] speed_reg;
   ppivr_pkg::ppivr_pwr_e pwr_reg;
   logic strap_load_reg;
   logic req_reg;
   logic req_clear;
   ppivr_pkg::ppivr_byte_t rd_next;
   ppivr_pkg::ppivr_byte_t rdata_reg;
   logic paged;

   assign paged = reg_addr_in[3];

   // page select lives in base register 7, only this field is kept here
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         page_reg <= `PPIVR_PAGE_RESET;
      end else if (reg_wr_in && reg_addr_in == `PPIVR_ADDR_BASE7) begin
         page_reg <= reg_wdata_in[`PPIVR_PAGE_SEL_HI:`PPIVR_PAGE_SEL_LO];
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         null_flag_reg <= `PPIVR_NULL_FLAG_RESET;
         speed_reg <= `PPIVR_SPEED_RESET;
      end else if (reg_wr_in && paged
                   && page_reg == `PPIVR_PAGE_VENDOR_DEP
                   && reg_addr_in == `PPIVR_ADDR_ARB_SPEED) begin
         null_flag_reg <= reg_wdata_in[`PPIVR_NULL_FLAG_BIT];
         speed_reg <= reg_wdata_in[`PPIVR_SPEED_HI:`PPIVR_SPEED_LO];
      end
   end

   // straps are sampled on the first clock after release, never in reset
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         strap_load_reg <= 1'b1;
         pwr_reg <= ppivr_pkg::ppivr_pwr_none;
      end else begin
         strap_load_reg <= 1'b0;
         if (reg_wr_in && reg_addr_in == `PPIVR_ADDR_PWR) begin
            // software value wins over a strap load in the same cycle
            pwr_reg <= ppivr_pkg::ppivr_pwr_e'(
               reg_wdata_in[`PPIVR_PWR_HI:`PPIVR_PWR_LO]);
         end else if (strap_load_reg) begin
            pwr_reg <= ppivr_pkg::ppivr_pwr_e'(
               power_class_straps_in);
         end
      end
   end

   // request clear: acks never clear; short packets only when flag is 0
   always_comb begin
      req_clear = 1'b0;
      if (pkt_end_in) begin
         if (null_flag_reg) begin
            req_clear = (pkt_bits_in > `PPIVR_ACK_BITS);
         end else begin
            req_clear = (pkt_bits_in != `PPIVR_ACK_BITS);
         end
      end
   end

   // a new request in the clearing cycle survives
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         req_reg <= 1'b0;
      end else if (req_set_in) begin
         req_reg <= 1'b1;
      end else if (req_clear) begin
         req_reg <= 1'b0;
      end
   end

   always_comb begin
      rd_next = 8'h00;
      if (paged && page_reg == `PPIVR_PAGE_IDENT) begin
         case (reg_addr_in)
            `PPIVR_ADDR_COMPLIANCE: rd_next = `PPIVR_COMPLIANCE_VAL;
            `PPIVR_ADDR_OUI_HI: rd_next = MAKER_OUI[23:16];
            `PPIVR_ADDR_OUI_MID: rd_next = MAKER_OUI[15:8];
            `PPIVR_ADDR_OUI_LO: rd_next = MAKER_OUI[7:0];
            `PPIVR_ADDR_PART_HI: rd_next = PART_IDENT[23:16];
            `PPIVR_ADDR_PART_MID: rd_next = PART_IDENT[15:8];
            `PPIVR_ADDR_PART_LO: rd_next = PART_IDENT[7:0];
            default: rd_next = 8'h00;
         endcase
      end else if (paged && page_reg == `PPIVR_PAGE_VENDOR_DEP) begin
         case (reg_addr_in)
            `PPIVR_ADDR_ARB_SPEED: begin
               rd_next = 8'h00;
               rd_next[`PPIVR_NULL_FLAG_BIT] = null_flag_reg;
               rd_next[`PPIVR_SPEED_HI:`PPIVR_SPEED_LO] = speed_reg;
            end
            default: rd_next = 8'h00;
         endcase
      end else if (reg_addr_in == `PPIVR_ADDR_BASE7) begin
         rd_next = 8'h00;
         rd_next[`PPIVR_PAGE_SEL_HI:`PPIVR_PAGE_SEL_LO] = page_reg;
      end else if (reg_addr_in == `PPIVR_ADDR_PWR) begin
         rd_next = {5'h00, pwr_reg};
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_reg <= rd_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign page_sel_out = page_reg;
   assign null_packet_action_flag_out = null_flag_reg;
   assign link_speed_out = speed_reg;
   assign self_id_pwr_out = pwr_reg;
   assign arb_req_pending_out = req_reg;
endmodule

// *** logic/ppivr_defs.svh ***
// register offsets, field positions, reset values and codes of the paged block
`ifndef PPIVR_DEFS_SVH
`define PPIVR_DEFS_SVH
`define PPIVR_PAGE_IDENT 3'h1
`define PPIVR_PAGE_VENDOR_DEP 3'h7
`define PPIVR_ADDR_BASE7 4'h7
`define PPIVR_ADDR_PWR 4'h4
`define PPIVR_PAGE_SEL_HI 7
`define PPIVR_PAGE_SEL_LO 5
`define PPIVR_PWR_HI 2
`define PPIVR_PWR_LO 0
`define PPIVR_ADDR_COMPLIANCE 4'h8
`define PPIVR_ADDR_ID_RSVD 4'h9
`define PPIVR_ADDR_OUI_HI 4'ha
`define PPIVR_ADDR_OUI_MID 4'hb
`define PPIVR_ADDR_OUI_LO 4'hc
`define PPIVR_ADDR_PART_HI 4'hd
`define PPIVR_ADDR_PART_MID 4'he
`define PPIVR_ADDR_PART_LO 4'hf
`define PPIVR_ADDR_ARB_SPEED 4'h8
`define PPIVR_COMPLIANCE_VAL 8'h01
`define PPIVR_NULL_FLAG_BIT 7
`define PPIVR_SPEED_HI 1
`define PPIVR_SPEED_LO 0
`define PPIVR_NULL_FLAG_RESET 1'h0
`define PPIVR_SPEED_RESET 2'h0
`define PPIVR_PAGE_RESET 3'h0
`define PPIVR_ACK_BITS 16'h0008
`define PPIVR_OUI_DEFAULT 24'h123456
`define PPIVR_PART_DEFAULT 24'habcdef
`endif

// *** logic/ppivr_pkg.sv ***
// types of the paged identification and vendor register block
package ppivr_pkg;
   typedef logic [7:0] ppivr_byte_t;
   typedef enum logic [2:0] {
      ppivr_pwr_none = 3'b000,
      ppivr_pwr_self15 = 3'b001,
      ppivr_pwr_self30 = 3'b010,
      ppivr_pwr_self45 = 3'b011,
      ppivr_pwr_may_bus3 = 3'b100,
      ppivr_pwr_rsvd = 3'b101,
      ppivr_pwr_bus3_need3 = 3'b110,
      ppivr_pwr_bus3_need7 = 3'b111
   } ppivr_pwr_e;
endpackage

// *** tb/ppivr_regs_assertions.sv ***
// port assertions of the paged register block
`timescale 1ns/100ps
module ppivr_regs_chk (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic pkt_end_in,
   input wire logic [15:0] pkt_bits_in,
   input wire logic req_set_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [2:0] page_sel_out,
   input wire logic null_packet_action_flag_out,
   input wire logic [1:0] link_speed_out,
   input wire logic [2:0] self_id_pwr_out,
   input wire logic arb_req_pending_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic w8, ev, flg;
   assign w8 = reg_wr_in && page_sel_out == 3'h7 && reg_addr_in == 4'h8;
   assign ev = pkt_end_in && !req_set_in;
   assign flg = null_packet_action_flag_out;
   a_page_sel_take: assert property (
      reg_wr_in && reg_addr_in == 4'h7
      |=> page_sel_out == $past(reg_wdata_in[7:5]))
      else $error("page select not taken");
   a_compliance_fixed: assert property (
      reg_rd_in && page_sel_out == 3'h1 && reg_addr_in == 4'h8
      |=> reg_rdata_out == 8'h01)
      else $error("compliance level wrong");
   a_test_read_zero: assert property (
      reg_rd_in && page_sel_out == 3'h7 && reg_addr_in > 4'h8
      |=> reg_rdata_out == 8'h00)
      else $error("test address not zero");
   a_flag_write: assert property (
      w8 |=> flg == $past(reg_wdata_in[7])) else $error("flag not written");
   a_speed_write: assert property (
      w8 |=> link_speed_out == $past(reg_wdata_in[1:0]))
      else $error("speed not written");
   a_power_write: assert property (
      reg_wr_in && reg_addr_in == 4'h4
      |=> self_id_pwr_out == $past(reg_wdata_in[2:0]))
      else $error("power class not replaced");
   a_req_clear: assert property (
      ev && (flg ? pkt_bits_in > 16'h8 : pkt_bits_in != 16'h8)
      |=> !arb_req_pending_out)
      else $error("request not cleared");
   a_req_keep: assert property (
      ev && (flg ? pkt_bits_in <= 16'h8 : pkt_bits_in == 16'h8)
      |=> $stable(arb_req_pending_out))
      else $error("request wrongly cleared");
endmodule
bind ppivr_regs ppivr_regs_chk chk (.*);

// *** tb/ppivr_llc_model.sv ***
// link controller model: register master and packet source
`timescale 1ns/100ps
module ppivr_llc_model (
   input wire logic clk_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [3:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   output logic pkt_end_out,
   output logic [15:0] bits_out,
   output logic set_out
);
   initial {addr_out, wdata_out, wr_out, rd_out} = '0;
   initial {pkt_end_out, bits_out, set_out} = '0;
   // page select writes go through here too
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= v;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      wdata_out <= ~v;
   endtask
   // data stands one cycle only, so sample mid cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      @(negedge clk_in);
      v = reg_rdata_in;
   endtask
   task automatic ev(input logic [15:0] n, input logic s);
      @(posedge clk_in);
      pkt_end_out <= 1'b1;
      bits_out <= n;
      set_out <= s;
      @(posedge clk_in);
      pkt_end_out <= 1'b0;
      set_out <= 1'b0;
      bits_out <= ~n;
   endtask
endmodule

// *** tb/test_ppivr_regs.sv ***
// bench of the paged register block
`timescale 1ns/100ps
module test_ppivr_regs;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [2:0] power_class_straps_in = 3'h5;
   logic [3:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, d;
   logic reg_wr_in, reg_rd_in, pkt_end_in, req_set_in;
   logic [15:0] pkt_bits_in;
   logic [2:0] page_sel_out, self_id_pwr_out;
   logic null_packet_action_flag_out, arb_req_pending_out;
   logic [1:0] link_speed_out;
   logic [47:0] ids = 48'h5a0f3c1e2d4b; // values arbitrary
   int fail_count = 0;
   int checks = 0;
   initial forever #20 clk_in = ~clk_in;
   ppivr_regs #(.MAKER_OUI(24'h5a0f3c), .PART_IDENT(24'h1e2d4b)) dut (.*);
   ppivr_llc_model llc (.clk_in(clk_in), .reg_rdata_in(reg_rdata_out),
      .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in),
      .rd_out(reg_rd_in), .pkt_end_out(pkt_end_in), .bits_out(pkt_bits_in),
      .set_out(req_set_in));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      llc.rd(a, d);
      check(d, e);
   endtask
   task automatic pk(input logic [15:0] n, input logic s, input logic e);
      llc.ev(n, s);
      @(negedge clk_in);
      check(8'(arb_req_pending_out), 8'(e));
   endtask
   task automatic rel;
      sys_rst_in <= 1'b0;
      repeat (2) @(negedge clk_in);
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      rel();
      check(8'(self_id_pwr_out), 8'h05);
      llc.wr(4'h7, 8'h20);
      rchk(4'h7, 8'h20);
      for (int i = 0; i < 6; i++)
         rchk(4'(10 + i), ids[47 - 8 * i -: 8]);
      llc.wr(4'h8, 8'hff);
      rchk(4'h8, 8'h01);
      rchk(4'h9, 8'h00);
      llc.wr(4'h7, 8'he0);
      rchk(4'h8, 8'h00);
      llc.wr(4'h8, 8'h83);
      rchk(4'h8, 8'h83);
      for (int a = 9; a < 16; a++) begin
         llc.wr(4'(a), 8'hff);
         rchk(4'(a), 8'h00);
      end
      pk(16'h9, 1'b1, 1'b1);
      pk(16'h8, 1'b0, 1'b1);
      pk(16'h0, 1'b0, 1'b1);
      pk(16'h5, 1'b0, 1'b1);
      pk(16'h9, 1'b0, 1'b0);
      llc.wr(4'h8, 8'h00);
      pk(16'h8, 1'b1, 1'b1);
      pk(16'h8, 1'b0, 1'b1);
      pk(16'h0, 1'b0, 1'b0);
      pk(16'h8, 1'b1, 1'b1);
      pk(16'h5, 1'b0, 1'b0);
      for (int c = 0; c < 8; c++) begin
         llc.wr(4'h4, 8'(c));
         @(negedge clk_in);
         check(8'(self_id_pwr_out), 8'(c));
      end
      llc.wr(4'h8, 8'h80);
      sys_rst_in <= 1'b1;
      power_class_straps_in <= 3'h2;
      repeat (2) @(posedge clk_in);
      rel();
      check(8'(self_id_pwr_out), 8'h02);
      check(8'(null_packet_action_flag_out), 8'h00);
      report_and_stop();
   end
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
endmodule
